// file: shared/codec_pkg.sv
package codec_pkg;

  // System clock rate
  localparam int CLK_MHZ = 250;

  // Power-down after sync silence
  localparam int POWERDOWN_IDLE_US = 2000;
  localparam int POWERDOWN_IDLE_CYCLES = POWERDOWN_IDLE_US * CLK_MHZ;

  // Receive mute after power-up
  localparam int MUTE_MS = 10;
  localparam int MUTE_CYCLES = MUTE_MS * 1000 * CLK_MHZ;

  // Decoder update delay
  localparam int DECODE_US = 10;
  localparam int DECODE_CYCLES = DECODE_US * CLK_MHZ;

  // A pin without an edge for this long counts as a static level
  localparam int STATIC_NS = 32000;
  localparam int STATIC_CYCLES = STATIC_NS * CLK_MHZ / 1000;

  // Framing and conversion figures
  localparam int CODE_BITS = 8;
  localparam int LONG_FRAME_MIN_BITS = 3;
  localparam int DIV_2048 = 8;
  localparam int DIV_1536 = 6;
  localparam int SAR_STEPS = 8;
  localparam int TX_LIVE_PULSE = 2;

  // Register byte addresses
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] RX_CODE_ADDR = 12'h008;
  localparam logic [11:0] TX_CODE_ADDR = 12'h00C;

  // Control fields and reset value
  localparam int CTRL_SOFT_PDN_BIT = 0;
  localparam int CTRL_ALAW_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // Status field positions
  localparam int ST_POWERED = 0;
  localparam int ST_SYNC_MODE = 1;
  localparam int ST_LONG_FRAME = 2;
  localparam int ST_RX_BCLK_RUN = 3;
  localparam int ST_SEL_2048 = 4;
  localparam int ST_MUTED = 5;
  localparam int ST_TX_LIVE = 6;
  localparam int ST_DECODING = 7;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial pins, all sampled on aclk
  localparam int PIN_COUNT = 7;
  typedef struct packed {
    logic tx_master_clock;
    logic rx_master_clock_or_powerdown;
    logic tx_bit_clock;
    logic rx_bit_clock_or_rate_select;
    logic tx_frame_sync;
    logic rx_frame_sync;
    logic pcm_in;
  } codec_pins_t;

  // Pin bit positions
  localparam int P_TX_MASTER_CLOCK = 6;
  localparam int P_MCLKR = 5;
  localparam int P_TX_BIT_CLOCK = 4;
  localparam int P_BCLKR = 3;
  localparam int P_FSX = 2;
  localparam int P_FSR = 1;

  typedef enum logic [1:0] {
    POWER_DOWN = 2'b01,
    POWER_UP = 2'b10
  } power_state_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_ARMED = 4'b0010,
    TX_SHIFT = 4'b0100,
    TX_HOLD = 4'b1000
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_t;

endpackage : codec_pkg

// file: hw/pin_edges.sv
`timescale 1ns/1ps
// Rise and fall detection for a group of synchronous pins
module pin_edges #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin levels and edges
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] prev; // Level one cycle ago
  } edge_state_t;

  edge_state_t s;
  edge_state_t next_s;

  // Edges compare the live level with the held one
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign rise[i] = level[i] & ~s.prev[i];
      assign fall[i] = ~level[i] & s.prev[i];
    end
  endgenerate

  // Next value
  always_comb
  begin
    next_s.prev = level;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    // Reset takes the live level, so no false edge follows
    if (!aresetn)
      s.prev <= level;
    else
      s <= next_s;
  end

endmodule : pin_edges

// file: hw/activity_watch.sv
`timescale 1ns/1ps
// Tells a running clock pin from a static level
module activity_watch #(
  parameter int LIMIT = 8000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Any edge on the watched pin
  input wire logic pin_edge,
  output logic running
);

  localparam int CW = $clog2(LIMIT + 1);

  typedef struct packed {
    logic [CW-1:0] quiet; // Cycles since an edge
    logic run; // Edge seen within the window
  } watch_state_t;

  watch_state_t s;
  watch_state_t next_s;

  assign running = s.run;

  // Restart on each edge, saturate when quiet
  always_comb
  begin
    next_s = s;
    if (pin_edge)
      next_s.quiet = '0;
    else if (s.quiet != CW'(LIMIT))
      next_s.quiet = s.quiet + 1'b1;
    next_s.run = (next_s.quiet != CW'(LIMIT));
  end

  // Starts as static, so reset looks like a fixed level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '{quiet: CW'(LIMIT), run: 1'b0};
    else
      s <= next_s;
  end

endmodule : activity_watch

// file: hw/pcm_codec_serial_port.sv
`timescale 1ns/1ps
// Contract
// R1: Reset lands in power-down, outputs undriven
// R2: Controller powers up via low/clock plus syncs
// R3: Power down 2 ms after last sync
// R4: First frame sync pulse powers up
// R5: pcm_out undriven until second tx sync
// R6: Sync mode: static receive master level powers
// R7: Static rate select: tx bit clock shared
// R8: Rate select maps divider, inverted for mu-law
// R9: Extra 193rd master pulse absorbed per frame
// R10: Tx sync starts encode, shifts previous code
// R11: Receive samples on falling receive bit clock
// R12: Async master clocks at legal rates
// R13: Async syncs follow their own clocks
// R14: Bit clocks between 64 kHz and 2.048 MHz
// R15: Short frame mode after power-up
// R16: Short tx: fall arms, rises shift, fall ends
// R17: Short rx: fall arms, eight falls capture
// R18: Frame mode sensed from tx sync width
// R19: Long tx starts at later sync/clock rise
// R20: Long tx ends at later fall/sync low
// R21: Long rx: sync rise, eight falls capture
// R22: Sync samples, encodes, buffers for next frame
// R23: Decoder output updates 10 us after slot
// R24: Receive output muted 10 ms at power-up
// R25: Tx frame sync is 8 kHz pulse train
// R26: Slot indicator pulled low during tx slot
// R27: Code travels sign first, MSB to LSB
module pcm_codec_serial_port #(
  parameter int ADDR_W = 12,
  parameter int POWERDOWN_CYCLES = codec_pkg::POWERDOWN_IDLE_CYCLES,
  parameter int MUTE_CYCLES = codec_pkg::MUTE_CYCLES,
  parameter int STATIC_CYCLES = codec_pkg::STATIC_CYCLES,
  parameter int DECODE_CYCLES = codec_pkg::DECODE_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial pins
  input wire codec_pkg::codec_pins_t pins,
  output logic pcm_out,
  output logic pcm_out_oe,
  input wire logic tx_slot_indicator_in,
  output logic tx_slot_indicator_out,
  output logic tx_slot_indicator_oe,
  // Converter side
  input wire logic [7:0] encoder_code,
  output logic [7:0] analog_receive_code,
  output logic analog_receive_enable,
  output logic analog_receive_mute
);

  localparam int IW = $clog2(POWERDOWN_CYCLES + 1);
  localparam int MW = $clog2(MUTE_CYCLES + 1);
  localparam int DW = $clog2(DECODE_CYCLES + 1);

  typedef struct packed {
    codec_pkg::power_state_t power; // Power mode
    logic [IW-1:0] idle; // Cycles since a sync
    logic [MW-1:0] mute; // Mute left
    logic [1:0] fsx_count; // Tx syncs, saturating
    logic [1:0] fsx_len; // Falls in this tx sync
    logic long_mode; // Mode from last tx sync
    logic [3:0] div; // Master divider
    logic [2:0] sar_step; // Encode step
    logic encoding; // Encode running
    logic [7:0] sample; // Taken at sync
    logic [7:0] tx_buffer; // Code for next frame
    codec_pkg::tx_state_t tx; // Tx slot state
    logic tx_fresh; // Sync rose, slot unopened
    logic [7:0] tx_shift; // Outgoing bits
    logic [2:0] tx_idx; // Bits sent minus one
    logic tx_live; // Slot may drive
    logic dx; // pcm_out level
    logic dx_oe; // pcm_out enable
    logic tsx_oe; // Indicator low
    codec_pkg::rx_state_t rx; // Rx slot state
    logic [2:0] rx_idx; // Bits taken so far
    logic [7:0] rx_shift; // Incoming bits
    logic [7:0] rx_code; // Last full byte
    logic decoding; // Decode running
    logic [DW-1:0] dec_count; // Decode left
    logic [7:0] dac; // Decoder code
    logic rx_en; // Output enabled
    logic rx_mute; // Output muted
    logic [1:0] ctrl; // Control bits
    logic aw_got; // Address held
    logic w_got; // Data held
    logic [ADDR_W-1:0] waddr; // Held address
    logic [31:0] wdat; // Held data
    logic [3:0] wstb; // Held strobes
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;

  // Pin edges and clock activity
  logic [codec_pkg::PIN_COUNT-1:0] rise;
  logic [codec_pkg::PIN_COUNT-1:0] fall;
  logic mclkr_run;
  logic bclkr_run;

  pin_edges #(
    .WIDTH(codec_pkg::PIN_COUNT)
  ) u_edges (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(pins),
    .rise(rise),
    .fall(fall)
  );

  // Receive master clock: running means asynchronous mode
  activity_watch #(
    .LIMIT(STATIC_CYCLES)
  ) u_mclkr_watch (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_edge(rise[codec_pkg::P_MCLKR] | fall[codec_pkg::P_MCLKR]),
    .running(mclkr_run)
  );

  // Receive bit clock: running or a rate select level
  activity_watch #(
    .LIMIT(STATIC_CYCLES)
  ) u_bclkr_watch (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_edge(rise[codec_pkg::P_BCLKR] | fall[codec_pkg::P_BCLKR]),
    .running(bclkr_run)
  );

  // Derived conditions
  logic sync_mode;
  logic pdn_request;
  logic sel_2048;
  logic [3:0] div_last;
  logic rbclk_fall;
  logic fs_pulse;
  logic [31:0] status_word;

  always_comb
  begin
    sync_mode = ~mclkr_run;
    // Static high on the shared pin, or software, asks for power-down
    pdn_request = (sync_mode & pins.rx_master_clock_or_powerdown) //R6
      | s.ctrl[codec_pkg::CTRL_SOFT_PDN_BIT];
    // Clocked or high picks 2.048 MHz on A-law, the inverse on mu-law
    sel_2048 = (bclkr_run | pins.rx_bit_clock_or_rate_select)
      ~^ s.ctrl[codec_pkg::CTRL_ALAW_BIT]; //R8
    div_last = sel_2048 ? 4'(codec_pkg::DIV_2048 - 1) : 4'(codec_pkg::DIV_1536 - 1);
    // Static receive clock: use tx clock
    rbclk_fall = bclkr_run ? fall[codec_pkg::P_BCLKR] : fall[codec_pkg::P_TX_BIT_CLOCK]; //R7 R11
    fs_pulse = rise[codec_pkg::P_FSX] | rise[codec_pkg::P_FSR];
    status_word = '0;
    status_word[codec_pkg::ST_POWERED] = (s.power == codec_pkg::POWER_UP);
    status_word[codec_pkg::ST_SYNC_MODE] = sync_mode;
    status_word[codec_pkg::ST_LONG_FRAME] = s.long_mode;
    status_word[codec_pkg::ST_RX_BCLK_RUN] = bclkr_run;
    status_word[codec_pkg::ST_SEL_2048] = sel_2048;
    status_word[codec_pkg::ST_MUTED] = s.rx_mute;
    status_word[codec_pkg::ST_TX_LIVE] = s.tx_live;
    status_word[codec_pkg::ST_DECODING] = s.decoding;
  end

  // Outputs straight from the state register; indicator level tied low
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign pcm_out = s.dx;
  assign pcm_out_oe = s.dx_oe;
  assign tx_slot_indicator_out = 1'b0;
  assign tx_slot_indicator_oe = s.tsx_oe;
  assign analog_receive_code = s.dac;
  assign analog_receive_enable = s.rx_en;
  assign analog_receive_mute = s.rx_mute;

  // Register read data
  function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] a,
                                            input logic [31:0] st);
    logic hit;
    logic [31:0] w;
    hit = 1'b1;
    w = '0;
    if (a == ADDR_W'(codec_pkg::CTRL_ADDR))
      w[1:0] = s.ctrl;
    else if (a == ADDR_W'(codec_pkg::STATUS_ADDR))
      w = st;
    else if (a == ADDR_W'(codec_pkg::RX_CODE_ADDR))
      w[7:0] = s.rx_code;
    else if (a == ADDR_W'(codec_pkg::TX_CODE_ADDR))
      w[7:0] = s.tx_buffer;
    else
      hit = 1'b0;
    return {hit, w};
  endfunction : read_word

  // All next-state logic
  always_comb
  begin
    logic [32:0] rd;
    logic start_slot;
    logic end_slot;
    rd = '0;
    start_slot = 1'b0;
    end_slot = 1'b0;
    next_s = s;

    // Power control
    unique case (s.power)
      codec_pkg::POWER_DOWN:
      begin
        // Wake on the first frame sync pulse
        if (!pdn_request && fs_pulse) //R4
        begin
          next_s.power = codec_pkg::POWER_UP;
          next_s.mute = MW'(MUTE_CYCLES); //R24
          next_s.idle = '0;
        end
      end
      codec_pkg::POWER_UP:
      begin
        // Silence or request powers down
        if (pdn_request || s.idle == IW'(POWERDOWN_CYCLES - 1)) //R3 R6
          next_s.power = codec_pkg::POWER_DOWN;
        else if (fs_pulse)
          next_s.idle = '0;
        else
          next_s.idle = s.idle + 1'b1;
      end
    endcase

    // Mute countdown only while powered
    if (s.power == codec_pkg::POWER_UP && s.mute != '0)
      next_s.mute = s.mute - 1'b1; //R24
    next_s.rx_mute = (next_s.mute != '0);

    // Tx sync width decides short or long frames
    if (rise[codec_pkg::P_FSX])
      next_s.fsx_len = '0;
    else if (pins.tx_frame_sync && fall[codec_pkg::P_TX_BIT_CLOCK] && s.fsx_len != 2'h3)
      next_s.fsx_len = s.fsx_len + 1'b1;
    if (fall[codec_pkg::P_FSX])
      next_s.long_mode = (s.fsx_len >= 2'(codec_pkg::LONG_FRAME_MIN_BITS)); //R18

    // Tx sync restarts the divider, so a 193rd master pulse falls away
    if (rise[codec_pkg::P_FSX])
    begin
      next_s.div = '0; //R9
      next_s.sar_step = '0;
      next_s.encoding = 1'b1; //R22
      next_s.sample = encoder_code;
      next_s.tx_shift = s.tx_buffer; //R10
      next_s.tx_fresh = 1'b1;
      if (s.fsx_count != 2'(codec_pkg::TX_LIVE_PULSE))
        next_s.fsx_count = s.fsx_count + 1'b1; //R5
    end
    else if (rise[codec_pkg::P_TX_MASTER_CLOCK])
    begin
      // Successive approximation paced by the divided master clock
      if (s.div == div_last)
      begin
        next_s.div = '0;
        if (s.encoding)
        begin
          next_s.sar_step = s.sar_step + 1'b1;
          if (s.sar_step == 3'(codec_pkg::SAR_STEPS - 1))
          begin
            next_s.encoding = 1'b0;
            next_s.tx_buffer = s.sample; //R22
          end
        end
      end
      else
        next_s.div = s.div + 1'b1;
    end

    // Transmit slot
    unique case (s.tx)
      codec_pkg::TX_IDLE:
      begin
        if (!s.long_mode && pins.tx_frame_sync && fall[codec_pkg::P_TX_BIT_CLOCK])
          next_s.tx = codec_pkg::TX_ARMED; //R16
        else if (s.long_mode && s.tx_fresh && pins.tx_frame_sync && pins.tx_bit_clock)
          start_slot = 1'b1; //R19
      end
      codec_pkg::TX_ARMED:
      begin
        if (rise[codec_pkg::P_TX_BIT_CLOCK])
          start_slot = 1'b1; //R16
      end
      codec_pkg::TX_SHIFT:
      begin
        if (rise[codec_pkg::P_TX_BIT_CLOCK] && s.tx_idx != 3'h7)
        begin
          // Next bit, most significant first
          next_s.dx = s.tx_shift[6]; //R27
          next_s.tx_shift = {s.tx_shift[6:0], 1'b0};
          next_s.tx_idx = s.tx_idx + 1'b1;
        end
        else if (fall[codec_pkg::P_TX_BIT_CLOCK] && s.tx_idx == 3'h7)
        begin
          // Long frames wait for the sync to drop as well
          if (s.long_mode && pins.tx_frame_sync)
            next_s.tx = codec_pkg::TX_HOLD; //R20
          else
            end_slot = 1'b1; //R10 R16
        end
      end
      codec_pkg::TX_HOLD:
      begin
        if (!pins.tx_frame_sync)
          end_slot = 1'b1; //R20
      end
    endcase

    if (start_slot)
    begin
      // Sign bit goes out with the enable
      next_s.tx = codec_pkg::TX_SHIFT;
      next_s.tx_fresh = 1'b0;
      next_s.tx_idx = '0;
      next_s.dx = s.tx_shift[7]; //R27
      next_s.tx_live = (s.fsx_count == 2'(codec_pkg::TX_LIVE_PULSE)); //R5
      next_s.dx_oe = next_s.tx_live;
      next_s.tsx_oe = next_s.tx_live; //R26
    end
    if (end_slot)
    begin
      next_s.tx = codec_pkg::TX_IDLE;
      next_s.dx_oe = 1'b0;
      next_s.tsx_oe = 1'b0; //R26
      next_s.dx = 1'b0;
    end

    // Decoder output lands; a slot ending below restarts it and wins
    if (s.decoding)
    begin
      if (s.dec_count == DW'(1))
      begin
        next_s.decoding = 1'b0;
        next_s.dac = s.rx_code; //R23
      end
      else
        next_s.dec_count = s.dec_count - 1'b1;
    end

    // Receive slot
    unique case (s.rx)
      codec_pkg::RX_IDLE:
      begin
        if (!s.long_mode && pins.rx_frame_sync && rbclk_fall)
          next_s.rx = codec_pkg::RX_SHIFT; //R17
        else if (s.long_mode && rise[codec_pkg::P_FSR])
          next_s.rx = codec_pkg::RX_SHIFT; //R21
        next_s.rx_idx = '0;
      end
      codec_pkg::RX_SHIFT:
      begin
        if (rbclk_fall)
        begin
          next_s.rx_shift = {s.rx_shift[6:0], pins.pcm_in}; //R11 R27
          next_s.rx_idx = s.rx_idx + 1'b1;
          if (s.rx_idx == 3'h7)
          begin
            // Slot over: decode starts now
            next_s.rx = codec_pkg::RX_IDLE;
            next_s.rx_code = {s.rx_shift[6:0], pins.pcm_in};
            next_s.decoding = 1'b1; //R23
            next_s.dec_count = DW'(DECODE_CYCLES);
          end
        end
      end
    endcase

    // Power-down closes slots, releases outputs
    if (next_s.power == codec_pkg::POWER_DOWN)
    begin
      next_s.tx = codec_pkg::TX_IDLE; //R1
      next_s.rx = codec_pkg::RX_IDLE;
      next_s.dx_oe = 1'b0;
      next_s.tsx_oe = 1'b0;
      next_s.tx_live = 1'b0;
      next_s.fsx_count = '0;
      next_s.long_mode = 1'b0; //R15
      next_s.decoding = 1'b0;
      next_s.mute = '0;
      next_s.rx_mute = 1'b0;
    end
    next_s.rx_en = (next_s.power == codec_pkg::POWER_UP);

    // Bus write: address and data in either order
    if (awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.waddr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdat = wdata;
      next_s.wstb = wstrb;
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (next_s.aw_got && next_s.w_got && !s.bvalid)
    begin
      rd = read_word(next_s.waddr, status_word);
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = rd[32] ? codec_pkg::RESP_OKAY : codec_pkg::RESP_SLVERR;
      // Only the control word takes writes
      if (next_s.waddr == ADDR_W'(codec_pkg::CTRL_ADDR) && next_s.wstb[0])
        next_s.ctrl = next_s.wdat[1:0];
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // Bus read: one outstanding
    if (arvalid && s.arready)
    begin
      rd = read_word(araddr, status_word);
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rd[31:0];
      next_s.rresp = rd[32] ? codec_pkg::RESP_OKAY : codec_pkg::RESP_SLVERR;
    end
    else if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // State register; reset leaves the device powered down
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.power <= codec_pkg::POWER_DOWN; //R1
      s.tx <= codec_pkg::TX_IDLE;
      s.rx <= codec_pkg::RX_IDLE;
      s.ctrl <= codec_pkg::CTRL_RESET;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end
    else
      s <= next_s;
  end

endmodule : pcm_codec_serial_port

// file: dv/pcm_codec_serial_port_sva.sv
`timescale 1ns/1ps
module codec_sva #(
  parameter int MUTE_CYCLES = 500
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and watched outputs
  input wire codec_pkg::codec_pins_t pins,
  input wire logic pcm_out,
  input wire logic pcm_out_oe,
  input wire logic tx_slot_indicator_oe,
  input wire logic analog_receive_enable,
  input wire logic analog_receive_mute
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin aliases
  wire logic bx = pins.tx_bit_clock;
  wire logic fx = pins.tx_frame_sync;
  // Cycles muted so far
  int mute_len;
  always_ff @(posedge aclk)
  begin
    mute_len <= (aresetn && analog_receive_mute) ? mute_len + 1 : 0;
  end
  // Edges one cycle back
  sequence bx_up; $past(bx) && !$past(bx, 2); endsequence
  sequence bx_dn; !$past(bx) && $past(bx, 2); endsequence
  sequence fx_up; $past(fx) && !$past(fx, 2); endsequence
  sequence fx_dn; !$past(fx) && $past(fx, 2); endsequence
  a_reset_quiet: assert property ($rose(aresetn) |-> !pcm_out_oe && !analog_receive_enable)
    else $error("outputs live after reset");
  a_oe_start: assert property ($rose(pcm_out_oe) |-> bx_up or fx_up)
    else $error("bad enable");
  a_oe_end: assert property ($fell(pcm_out_oe) |-> bx_dn or fx_dn or ##[0:1] !analog_receive_enable)
    else $error("bad release");
  a_data_steady: assert property ($changed(pcm_out) && pcm_out_oe && $past(pcm_out_oe) |-> bx_up)
    else $error("data moved");
  a_slot_mark: assert property (pcm_out_oe |-> tx_slot_indicator_oe)
    else $error("slot indicator missing");
  a_oe_powered: assert property (pcm_out_oe |-> analog_receive_enable)
    else $error("driven while down");
  a_mute_on: assert property ($rose(analog_receive_enable) |-> ##[0:1] analog_receive_mute)
    else $error("no mute at power-up");
  a_mute_len: assert property ($fell(analog_receive_mute) && analog_receive_enable |-> mute_len inside {[MUTE_CYCLES - 1:MUTE_CYCLES + 1]})
    else $error("mute length wrong");
endmodule : codec_sva
bind pcm_codec_serial_port codec_sva #(.MUTE_CYCLES(MUTE_CYCLES)) u_sva (.aclk, .aresetn, .pins, .pcm_out, .pcm_out_oe, .tx_slot_indicator_oe, .analog_receive_enable, .analog_receive_mute);

// file: dv/highway_model.sv
`timescale 1ns/1ps
module highway_model #(
  parameter int HALF = 4,
  parameter int BITS = 48
) (
  // Clock
  input wire logic aclk,
  // Controls from the bench
  input wire logic run,
  input wire logic long_mode,
  input wire logic hold_down,
  input wire logic [7:0] rx_byte,
  // Pins toward the codec
  output codec_pkg::codec_pins_t pins
);
  // Frame phase; clocks run free
  int cnt = 0;
  int bitn;
  assign bitn = cnt / (2 * HALF);
  initial pins = '0;
  // Pins move just after the edge
  always @(posedge aclk)
  begin
    cnt <= (cnt + 1) % (2 * HALF * BITS);
    pins.tx_master_clock <= cnt[1];
    pins.rx_master_clock_or_powerdown <= hold_down;
    pins.tx_bit_clock <= (cnt % (2 * HALF)) < HALF;
    pins.rx_bit_clock_or_rate_select <= 1'b1;
    // One period short, three long
    pins.tx_frame_sync <= run && (long_mode ? bitn < 3 : bitn == BITS - 1);
    pins.rx_frame_sync <= run && (long_mode ? bitn < 3 : bitn == BITS - 1);
    // Toggles outside the slot
    pins.pcm_in <= (run && bitn < 8) ? rx_byte[7 - bitn] : !pins.pcm_in;
  end
endmodule : highway_model

// file: dv/pcm_codec_serial_port_tb.sv
`timescale 1ns/1ps
module pcm_codec_serial_port_tb;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [1:0] r;} row_t;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = '0, rdata, d;
  logic [1:0] bresp, rresp, s;
  logic awready, wready, bvalid, arready, rvalid, pcm_out, pcm_out_oe, tx_slot_indicator_oe;
  logic analog_receive_enable, analog_receive_mute, run = 0, long_mode = 0, hold_down = 0;
  logic [7:0] encoder_code = '0, analog_receive_code, rx_byte = '0;
  codec_pkg::codec_pins_t pins;
  int fails = 0, cmp_count = 0, fsx_n = 0;
  // Bus rows; data bit 31 drops strobe 0
  row_t rows [10] = '{'{1'b0, 12'h000, 32'h2, 2'h0}, '{1'b0, 12'h004, 32'h12, 2'h0},
    '{1'b1, 12'h000, 32'h0, 2'h0}, '{1'b0, 12'h004, 32'h2, 2'h0},
    '{1'b1, 12'h000, 32'h2, 2'h0}, '{1'b1, 12'h004, 32'hFF, 2'h0},
    '{1'b0, 12'h010, 32'h0, 2'h2}, '{1'b1, 12'h010, 32'h0, 2'h2},
    '{1'b1, 12'h000, 32'h80000000, 2'h0}, '{1'b0, 12'h000, 32'h2, 2'h0}};
  always #2 aclk = ~aclk;
  always @(posedge pins.tx_frame_sync) fsx_n++;
  // Short counts so the run stays brief
  pcm_codec_serial_port #(.POWERDOWN_CYCLES(2000), .MUTE_CYCLES(500), .STATIC_CYCLES(64),
    .DECODE_CYCLES(100)) u_dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .pins, .pcm_out, .pcm_out_oe,
    .tx_slot_indicator_in(!tx_slot_indicator_oe), .tx_slot_indicator_out(), .tx_slot_indicator_oe,
    .encoder_code, .analog_receive_code, .analog_receive_enable, .analog_receive_mute);
  highway_model u_hw (.aclk, .run, .long_mode, .hold_down, .rx_byte, .pins);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic timeout();
    fails++;
    $display("MISMATCH t=%0t wait expired", $time);
    give_verdict();
  endtask : timeout
  // One transfer; each channel held to its ready
  task automatic bus(input row_t r, output logic [31:0] dat, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= r.a;
    araddr <= r.a;
    wdata <= r.d;
    wstrb <= {3'h7, !r.d[31]};
    {awvalid, wvalid, bready} <= {3{r.wr}};
    {arvalid, rready} <= {2{!r.wr}};
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end
    while (!(bvalid && bready || rvalid && rready) && n < 50);
    dat = rdata;
    rsp = r.wr ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
    if (n >= 50) timeout();
  endtask : bus
  // Bounded wait for a level
  task automatic wait_lvl(input bit oe, input bit lvl);
    int n;
    for (n = 0; n < 5000; n++)
    begin
      @(posedge aclk);
      if ((oe ? pcm_out_oe : analog_receive_enable) === lvl) break;
    end
    if (n == 5000) timeout();
  endtask : wait_lvl
  // Mid-bit samples of one slot
  task automatic grab(input logic [7:0] exp);
    logic [7:0] b;
    repeat (3) @(posedge aclk);
    for (int i = 7; i >= 0; i--)
    begin
      b[i] = pcm_out;
      repeat (8) @(posedge aclk);
    end
    chk(32'(b), 32'(exp));
  endtask : grab
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      bus(rows[i], d, s);
      if (!rows[i].wr) chk(d, rows[i].d);
      chk(32'(s), 32'(rows[i].r));
    end
    // Short frames: wake, first slot stays quiet
    rx_byte <= 8'h3C;
    encoder_code <= 8'hA5;
    run <= 1'b1;
    wait_lvl(0, 1);
    chk(32'(analog_receive_mute), 32'h1);
    wait_lvl(1, 1);
    chk(fsx_n, 2);
    grab(8'hA5);
    repeat (2600) @(posedge aclk);
    chk(32'(analog_receive_code), 32'h3C);
    chk(32'(analog_receive_mute), 32'h0);
    bus('{1'b0, 12'h008, 32'h0, 2'h0}, d, s);
    chk(d, 32'h3C);
    // Long frames with new codes
    long_mode <= 1'b1;
    encoder_code <= 8'h5A;
    rx_byte <= 8'hC3;
    repeat (1200) @(posedge aclk);
    bus('{1'b0, 12'h004, 32'h0, 2'h0}, d, s);
    chk(32'(d[2]), 32'h1);
    wait_lvl(1, 0);
    wait_lvl(1, 1);
    grab(8'h5A);
    repeat (2600) @(posedge aclk);
    chk(32'(analog_receive_code), 32'hC3);
    // Sync silence powers down
    run <= 1'b0;
    repeat (1500) @(posedge aclk);
    chk(32'(analog_receive_enable), 32'h1);
    repeat (900) @(posedge aclk);
    chk(32'({analog_receive_enable, pcm_out_oe}), 32'h0);
    // Static high holds it down
    long_mode <= 1'b0;
    hold_down <= 1'b1;
    repeat (100) @(posedge aclk);
    run <= 1'b1;
    repeat (800) @(posedge aclk);
    chk(32'(analog_receive_enable), 32'h0);
    hold_down <= 1'b0;
    wait_lvl(0, 1);
    chk(32'(analog_receive_mute), 32'h1);
    give_verdict();
  end
endmodule : pcm_codec_serial_port_tb
